// ### rtl/rsdc_top.sv
// reset strap capture, decode and peripheral enable register
// Notes on behaviour
// R1 - Every strap is sampled while reset is held and the sample is the configuration afterwards.
// R2 - Byte-order strap 0 means big endian and 1 means little endian, little being the default.
// R3 - Boot code 00 is no boot, 01 host port or PCI by the PCI select, 10 reserved, 11 ext memory.
// R4 - Clock code 00 is the dedicated clock input, 01 CPU/4, 10 CPU/6, 11 reserved.
// R5 - EEPROM auto-init 1 configures PCI from EEPROM only when PCI is selected, else defaults.
// R6 - With PCI selected the speed strap picks 66 MHz when 0 and 33 MHz when 1.
// R7 - Host width strap 0 gives a 16-bit host bus with upper data idle, 1 a 32-bit host bus.
// R8 - Select code 00 host port, 01 Ethernet plus 16-bit or no host port, 10 PCI, 11 reserved.
// R9 - The registers decode within the 4K region at 0x01b3f000 on the internal config bus.
// R10 - Bits 31:7 of the peripheral enable register read fixed zero and ignore writes.
// R11 - Bit 6 enables video port 2, clear by default meaning disabled and powered down.
// R12 - Bit 5 enables video port 1, clear by default meaning disabled and powered down.
// R13 - An enable is accepted only after the unlock key has been written to the lock register.
// R14 - The board keeps the general-purpose 0 strap low in reset; high is flagged invalid.
// R15 - Sampled straps stay constant from reset release until the next reset.
module rsdc_top (
  input wire logic clk,
  input wire logic rstn,
  input wire rsdc_pkg::rsdc_straps_t strap_pins,
  input wire rsdc_pkg::rsdc_bus_req_t cfg_bus,
  output logic [31:0] cfg_rdata,
  output logic cfg_ack,
  output rsdc_pkg::rsdc_cfg_t dev_cfg,
  output logic video_port1_enable,
  output logic video_port2_enable,
  output logic config_locked
);

  rsdc_pkg::rsdc_straps_t sync1_q;
  rsdc_pkg::rsdc_straps_t sync2_q;
  rsdc_pkg::rsdc_straps_t sync3_q;
  rsdc_pkg::rsdc_straps_t strap_q;
  logic hit;
  logic [11:0] ofs;
  logic wr_pes;
  logic wr_lock;
  logic [31:0] rdata_d;

  // pins are asynchronous to clk; three stages, free running
  always_ff @(posedge clk) begin
    sync1_q <= strap_pins;
    sync2_q <= sync1_q;
    sync3_q <= sync2_q;
  end

  // R1 R15 capture during reset only, sample then holds while running
  // only an agreed level is taken, so a ringing strap cannot latch a half value
  always_ff @(posedge clk) begin
    if (!rstn) begin
      if (sync2_q == sync3_q) begin
        strap_q <= sync3_q;
      end
    end
  end

  // R2 R3 R4 R5 R6 R7 R8 R14 registered decode
  // default decode during reset keeps outputs defined before the first sample settles
  always_ff @(posedge clk) begin
    if (!rstn) begin
      dev_cfg <= rsdc_pkg::rsdc_decode(rsdc_pkg::RSDC_STRAP_DEFAULT);
    end else begin
      dev_cfg <= rsdc_pkg::rsdc_decode(strap_q);
    end
  end

  // R9 region and register decode
  always_comb begin
    hit = cfg_bus.req && ((cfg_bus.addr & rsdc_pkg::RSDC_REGION_MASK) == rsdc_pkg::RSDC_BASE);
    ofs = cfg_bus.addr[11:0];
    wr_pes = hit && cfg_bus.wr && (ofs == rsdc_pkg::RSDC_OFS_PES);
    wr_lock = hit && cfg_bus.wr && (ofs == rsdc_pkg::RSDC_OFS_LOCK);
  end

  // R13 key unlocks, any other value written to the lock register relocks
  always_ff @(posedge clk) begin
    if (!rstn) begin
      config_locked <= rsdc_pkg::RSDC_LOCK_RESET;
    end else if (wr_lock) begin
      config_locked <= (cfg_bus.wdata != rsdc_pkg::RSDC_UNLOCK_KEY);
    end
  end

  // R11 R12 video port enables; locked writes may only clear
  // disabling stays allowed while locked so software can always power down
  always_ff @(posedge clk) begin
    if (!rstn) begin
      video_port1_enable <= rsdc_pkg::RSDC_VP_RESET;
      video_port2_enable <= rsdc_pkg::RSDC_VP_RESET;
    end else if (wr_pes) begin
      if (config_locked) begin
        video_port1_enable <= video_port1_enable & cfg_bus.wdata[rsdc_pkg::RSDC_VP1_BIT];
        video_port2_enable <= video_port2_enable & cfg_bus.wdata[rsdc_pkg::RSDC_VP2_BIT];
      end else begin
        video_port1_enable <= cfg_bus.wdata[rsdc_pkg::RSDC_VP1_BIT];
        video_port2_enable <= cfg_bus.wdata[rsdc_pkg::RSDC_VP2_BIT];
      end
    end
  end

  // R10 read mux, reserved and unmapped bits read zero
  always_comb begin
    rdata_d = rsdc_pkg::RSDC_ZERO;
    if (hit && !cfg_bus.wr) begin
      case (ofs)
        rsdc_pkg::RSDC_OFS_PES: begin
          rdata_d[rsdc_pkg::RSDC_VP1_BIT] = video_port1_enable;
          rdata_d[rsdc_pkg::RSDC_VP2_BIT] = video_port2_enable;
        end
        rsdc_pkg::RSDC_OFS_LOCK: begin
          rdata_d[rsdc_pkg::RSDC_LOCK_BIT] = config_locked;
        end
        default: begin
          rdata_d = rsdc_pkg::RSDC_ZERO;
        end
      endcase
    end
  end

  // R9 every request answered one cycle later, so the bus never hangs
  always_ff @(posedge clk) begin
    if (!rstn) begin
      cfg_ack <= 1'b0;
      cfg_rdata <= rsdc_pkg::RSDC_ZERO;
    end else begin
      cfg_ack <= cfg_bus.req;
      cfg_rdata <= rdata_d;
    end
  end

  default clocking cb @(posedge clk); endclocking

  sequence s_unlock;
    wr_lock && (cfg_bus.wdata == rsdc_pkg::RSDC_UNLOCK_KEY);
  endsequence

  sequence s_vp2_set;
    wr_pes && cfg_bus.wdata[rsdc_pkg::RSDC_VP2_BIT];
  endsequence

  sequence s_pes_read;
    hit && !cfg_bus.wr && (ofs == rsdc_pkg::RSDC_OFS_PES);
  endsequence

  a_strap_sample: assert property (!rstn && (sync2_q == sync3_q) |=> strap_q == $past(sync3_q)) // R1
    else $error("strap not sampled during reset");
  a_strap_hold: assert property (disable iff (!rstn) $past(rstn) |-> $stable(strap_q)) // R15
    else $error("strap sample changed while running");
  a_endian_decode: assert property (disable iff (!rstn) // R2
    $past(rstn) |-> dev_cfg.byte_order_mode == $past(strap_q.byte_order_strap))
    else $error("byte order decode wrong");
  a_boot_decode: assert property (disable iff (!rstn) // R3
    $past(rstn) |-> dev_cfg.boot_pci == ($past(strap_q.boot_strap) == rsdc_pkg::RSDC_CODE_01
    && $past(strap_q.pci_select_strap)) && dev_cfg.boot_ext_mem ==
    ($past(strap_q.boot_strap) == rsdc_pkg::RSDC_CODE_11))
    else $error("boot decode wrong");
  a_clock_decode: assert property (disable iff (!rstn) // R4
    $past(rstn) |-> dev_cfg.clk_cpu_div6 == ($past(strap_q.ext_mem_clock_select)
    == rsdc_pkg::RSDC_CODE_10))
    else $error("clock select decode wrong");
  a_eeprom_gate: assert property (disable iff (!rstn) // R5
    dev_cfg.pci_eeprom_init |-> dev_cfg.pci_en)
    else $error("eeprom init without pci");
  a_pci_speed: assert property (disable iff (!rstn) // R6
    dev_cfg.pci_66mhz |-> dev_cfg.pci_en && !$past(strap_q.pci_speed_strap))
    else $error("pci speed decode wrong");
  a_host_width: assert property (disable iff (!rstn) // R7
    dev_cfg.host_port_32bit |-> dev_cfg.host_port_en && !dev_cfg.ethernet_en)
    else $error("32-bit host port with ethernet");
  a_periph_select: assert property (disable iff (!rstn) // R8
    dev_cfg.ethernet_en |-> !dev_cfg.pci_en && !dev_cfg.host_port_32bit)
    else $error("peripheral select conflict");
  a_bus_answer: assert property (disable iff (!rstn) cfg_bus.req |=> cfg_ack) // R9
    else $error("request not answered");
  a_reserved_zero: assert property (disable iff (!rstn) // R10
    s_pes_read |=> cfg_rdata[31:rsdc_pkg::RSDC_RSVD_LO] == '0)
    else $error("reserved bits not zero");
  a_locked_vp2: assert property (disable iff (!rstn) // R11
    config_locked && !video_port2_enable ##0 s_vp2_set |=> !video_port2_enable)
    else $error("video port 2 enabled while locked");
  a_locked_vp1: assert property (disable iff (!rstn) // R12
    config_locked && wr_pes && !video_port1_enable |=> !video_port1_enable)
    else $error("video port 1 enabled while locked");
  a_unlock_enable: assert property (disable iff (!rstn) // R13
    s_unlock ##1 s_vp2_set |=> video_port2_enable && !config_locked)
    else $error("unlocked enable not accepted");
  a_gp0_invalid: assert property (disable iff (!rstn) // R14
    $past(rstn) |-> dev_cfg.strap_invalid == $past(strap_q.gp0_strap))
    else $error("gp0 strap flag wrong");

  // bus answer, lock sequencing, reset defaults and boot, clock and Ethernet strap decode
  a_ack_single: assert property (disable iff (!rstn) // R9
    !cfg_bus.req |=> !cfg_ack)
    else $error("acknowledge without request");
  a_write_rdata: assert property (disable iff (!rstn) // R9
    cfg_bus.req && cfg_bus.wr |=> cfg_rdata == '0)
    else $error("write returned data");
  a_region_miss: assert property (disable iff (!rstn) // R9
    cfg_bus.req && ((cfg_bus.addr & rsdc_pkg::RSDC_REGION_MASK) != rsdc_pkg::RSDC_BASE)
    |=> cfg_rdata == '0)
    else $error("access outside region returned data");
  a_key_unlock: assert property (disable iff (!rstn) // R13
    s_unlock |=> !config_locked)
    else $error("key did not unlock");
  a_relock: assert property (disable iff (!rstn) // R13
    wr_lock && (cfg_bus.wdata != rsdc_pkg::RSDC_UNLOCK_KEY) |=> config_locked)
    else $error("wrong key left register unlocked");
  a_lock_hold: assert property (disable iff (!rstn) // R13
    !wr_lock |=> $stable(config_locked))
    else $error("lock changed without lock write");
  a_vp_hold: assert property (disable iff (!rstn) // R11 R12
    !wr_pes |=> $stable(video_port1_enable) && $stable(video_port2_enable))
    else $error("video enable changed without write");
  a_reset_default: assert property ( // R11 R12
    !rstn |=> !video_port1_enable && !video_port2_enable && config_locked && !cfg_ack)
    else $error("register defaults wrong in reset");
  a_boot_none: assert property (disable iff (!rstn) // R3
    $past(rstn) |-> dev_cfg.boot_none == ($past(strap_q.boot_strap)
    == rsdc_pkg::RSDC_CODE_00))
    else $error("no boot decode wrong");
  a_clock_div4: assert property (disable iff (!rstn) // R4
    $past(rstn) |-> dev_cfg.clk_cpu_div4 == ($past(strap_q.ext_mem_clock_select)
    == rsdc_pkg::RSDC_CODE_01))
    else $error("clock divide by four decode wrong");
  a_eth_select: assert property (disable iff (!rstn) // R8
    $past(rstn) |-> dev_cfg.ethernet_en == (!$past(strap_q.pci_select_strap)
    && $past(strap_q.ethernet_select_strap)))
    else $error("ethernet select decode wrong");

endmodule : rsdc_top

// ### rtl/rsdc_pkg.sv
// constants, carriers and decode for the reset strap configuration block
package rsdc_pkg;

  // register region and map
  localparam logic [31:0] RSDC_BASE = 32'h01b3f000;
  localparam logic [31:0] RSDC_REGION_MASK = 32'hfffff000;
  localparam logic [11:0] RSDC_OFS_PES = 12'h000;
  localparam logic [11:0] RSDC_OFS_LOCK = 12'h004;
  localparam logic [31:0] RSDC_UNLOCK_KEY = 32'h10c0010c;

  // field positions
  localparam int RSDC_VP1_BIT = 5;
  localparam int RSDC_VP2_BIT = 6;
  localparam int RSDC_LOCK_BIT = 0;
  localparam int RSDC_RSVD_LO = 7;

  // reset values
  localparam logic RSDC_VP_RESET = 1'b0;
  localparam logic RSDC_LOCK_RESET = 1'b1;
  localparam logic [31:0] RSDC_ZERO = 32'h0;

  // two-bit strap codes
  localparam logic [1:0] RSDC_CODE_00 = 2'h0;
  localparam logic [1:0] RSDC_CODE_01 = 2'h1;
  localparam logic [1:0] RSDC_CODE_10 = 2'h2;
  localparam logic [1:0] RSDC_CODE_11 = 2'h3;

  // raw strap levels as sampled
  typedef struct packed {
    logic byte_order_strap;
    logic [1:0] boot_strap;
    logic [1:0] ext_mem_clock_select;
    logic eeprom_autoinit_strap;
    logic pci_speed_strap;
    logic host_width_strap_pin;
    logic pci_select_strap;
    logic ethernet_select_strap;
    logic gp0_strap;
  } rsdc_straps_t;

  // board default: little endian, everything else low
  localparam rsdc_straps_t RSDC_STRAP_DEFAULT = 11'h400;

  // decoded device configuration
  typedef struct packed {
    logic byte_order_mode;
    logic boot_none;
    logic boot_host_port;
    logic boot_pci;
    logic boot_ext_mem;
    logic boot_invalid;
    logic clk_ext_mem_clock_input;
    logic clk_cpu_div4;
    logic clk_cpu_div6;
    logic clk_invalid;
    logic host_port_en;
    logic host_port_32bit;
    logic ethernet_en;
    logic pci_en;
    logic pci_eeprom_init;
    logic pci_66mhz;
    logic periph_invalid;
    logic strap_invalid;
  } rsdc_cfg_t;

  // one internal config bus request
  typedef struct packed {
    logic req;
    logic wr;
    logic [31:0] addr;
    logic [31:0] wdata;
  } rsdc_bus_req_t;

  // straps to device configuration
  function automatic rsdc_cfg_t rsdc_decode(input rsdc_straps_t s);
    rsdc_cfg_t c;
    logic [1:0] sel;
    c = '0;
    sel = {s.pci_select_strap, s.ethernet_select_strap};
    c.byte_order_mode = s.byte_order_strap;
    c.boot_none = (s.boot_strap == RSDC_CODE_00);
    c.boot_host_port = (s.boot_strap == RSDC_CODE_01) && !s.pci_select_strap;
    c.boot_pci = (s.boot_strap == RSDC_CODE_01) && s.pci_select_strap;
    c.boot_invalid = (s.boot_strap == RSDC_CODE_10);
    c.boot_ext_mem = (s.boot_strap == RSDC_CODE_11);
    c.clk_ext_mem_clock_input = (s.ext_mem_clock_select == RSDC_CODE_00);
    c.clk_cpu_div4 = (s.ext_mem_clock_select == RSDC_CODE_01);
    c.clk_cpu_div6 = (s.ext_mem_clock_select == RSDC_CODE_10);
    c.clk_invalid = (s.ext_mem_clock_select == RSDC_CODE_11);
    c.host_port_en = (sel == RSDC_CODE_00) || ((sel == RSDC_CODE_01) && !s.host_width_strap_pin);
    c.host_port_32bit = (sel == RSDC_CODE_00) && s.host_width_strap_pin;
    c.ethernet_en = (sel == RSDC_CODE_01);
    c.pci_en = (sel == RSDC_CODE_10);
    c.pci_eeprom_init = (sel == RSDC_CODE_10) && s.eeprom_autoinit_strap;
    c.pci_66mhz = (sel == RSDC_CODE_10) && !s.pci_speed_strap;
    c.periph_invalid = (sel == RSDC_CODE_11);
    c.strap_invalid = s.gp0_strap;
    return c;
  endfunction : rsdc_decode

endpackage : rsdc_pkg

// ### bench/rsdc_board.sv
// board pull resistors that set the strap levels
module rsdc_board (
  input wire rsdc_pkg::rsdc_straps_t level,
  output rsdc_pkg::rsdc_straps_t pins
);
  always_comb begin
    pins = level;
    pins.gp0_strap = 1'b0; // pulldown only, a high level is never fitted
  end
endmodule : rsdc_board

// ### bench/rsdc_top_tb.sv
// self-checking bench for strap capture and peripheral enable register
module rsdc_top_tb;
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [31:0] PES = 32'h01b3f000;
  localparam logic [31:0] LCK = 32'h01b3f004;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  rsdc_pkg::rsdc_straps_t level = '0;
  rsdc_pkg::rsdc_straps_t pins;
  rsdc_pkg::rsdc_bus_req_t bus = '0;
  rsdc_pkg::rsdc_cfg_t dev_cfg;
  logic [31:0] cfg_rdata;
  logic cfg_ack;
  logic video_port1_enable;
  logic video_port2_enable;
  logic config_locked;
  logic [31:0] r;
  logic [31:0] d;
  rsdc_pkg::rsdc_cfg_t e;
  int mismatches = 0;
  int compares = 0;
  int seed = 69558;

  rsdc_board rsdc_board_inst (.level(level), .pins(pins));
  rsdc_top rsdc_top_inst (.clk(clk), .rstn(rstn), .strap_pins(pins), .cfg_bus(bus),
    .cfg_rdata(cfg_rdata), .cfg_ack(cfg_ack), .dev_cfg(dev_cfg),
    .video_port1_enable(video_port1_enable), .video_port2_enable(video_port2_enable),
    .config_locked(config_locked));

  // 200 MHz clock
  initial begin
    forever #2.5 clk = ~clk;
  end

  // expected configuration from strap levels
  function automatic rsdc_pkg::rsdc_cfg_t exp_cfg(input rsdc_pkg::rsdc_straps_t s);
    rsdc_pkg::rsdc_cfg_t c;
    logic [1:0] p;
    c = '0;
    p = {s.pci_select_strap, s.ethernet_select_strap};
    c.byte_order_mode = s.byte_order_strap;
    c.boot_none = s.boot_strap == 2'h0;
    c.boot_host_port = s.boot_strap == 2'h1 && !s.pci_select_strap;
    c.boot_pci = s.boot_strap == 2'h1 && s.pci_select_strap;
    c.boot_invalid = s.boot_strap == 2'h2;
    c.boot_ext_mem = s.boot_strap == 2'h3;
    c.clk_ext_mem_clock_input = s.ext_mem_clock_select == 2'h0;
    c.clk_cpu_div4 = s.ext_mem_clock_select == 2'h1;
    c.clk_cpu_div6 = s.ext_mem_clock_select == 2'h2;
    c.clk_invalid = s.ext_mem_clock_select == 2'h3;
    c.host_port_en = p == 2'h0 || (p == 2'h1 && !s.host_width_strap_pin);
    c.host_port_32bit = p == 2'h0 && s.host_width_strap_pin;
    c.ethernet_en = p == 2'h1;
    c.pci_en = p == 2'h2;
    c.pci_eeprom_init = p == 2'h2 && s.eeprom_autoinit_strap;
    c.pci_66mhz = p == 2'h2 && !s.pci_speed_strap;
    c.periph_invalid = p == 2'h3;
    return c;
  endfunction : exp_cfg

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // one request strobe, answer sampled one cycle later
  task automatic acc(input logic w, input logic [31:0] a, input logic [31:0] d,
    output logic [31:0] rd);
    @(posedge clk);
    #1 bus = {1'b1, w, a, d};
    @(posedge clk);
    #1 bus.req = 1'b0;
    chk("ack", 32'h1, {31'h0, cfg_ack});
    rd = cfg_rdata;
  endtask : acc

  // two writes in adjacent cycles, strobe held high between them
  task automatic acc_pair(input logic [31:0] a0, input logic [31:0] d0,
    input logic [31:0] a1, input logic [31:0] d1);
    @(posedge clk);
    #1 bus = {1'b1, 1'b1, a0, d0};
    @(posedge clk);
    #1 bus = {1'b1, 1'b1, a1, d1};
    chk("ack_first", 32'h1, {31'h0, cfg_ack});
    @(posedge clk);
    #1 bus.req = 1'b0;
    chk("ack_second", 32'h1, {31'h0, cfg_ack});
  endtask : acc_pair

  task automatic print_verdict();
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : print_verdict

  // watchdog well beyond the expected 162 or so cycles
  initial begin
    #100us;
    mismatches++;
    print_verdict();
  end

  initial begin
    // straps: every code of each field, other bits random, then runtime wiggle
    for (int i = 0; i < 8; i++) begin
      @(posedge clk);
      #1 rstn = 1'b0;
      level = rsdc_pkg::rsdc_straps_t'(11'($random(seed)));
      level.boot_strap = i[1:0];
      level.ext_mem_clock_select = i[1:0];
      {level.pci_select_strap, level.ethernet_select_strap} = 2'(i + 1);
      e = exp_cfg(level);
      repeat (10) @(posedge clk);
      #1 rstn = 1'b1;
      @(posedge clk);
      #1;
      chk("dev_cfg", {14'h0, e}, {14'h0, dev_cfg});
      level = ~level; // pins move while running, must be ignored
      repeat (3) @(posedge clk);
      #1 chk("dev_cfg_hold", {14'h0, e}, {14'h0, dev_cfg});
    end
    $display("test straps done");
    // register reset values and lock
    acc(1'b0, PES, 32'h0, r);
    chk("pes_reset", 32'h0, r);
    acc(1'b0, LCK, 32'h0, r);
    chk("lock_reset", 32'h1, r);
    acc(1'b1, PES, 32'hffffffff, r);
    acc(1'b0, PES, 32'h0, r);
    chk("pes_locked", 32'h0, r);
    acc(1'b1, LCK, rsdc_pkg::RSDC_UNLOCK_KEY, r);
    chk("unlocked", 32'h0, {31'h0, config_locked});
    acc(1'b1, PES, 32'hffffffff, r);
    acc(1'b0, PES, 32'h0, r);
    chk("pes_rw", 32'h60, r);
    chk("vp_pins", 32'h3, {30'h0, video_port2_enable, video_port1_enable});
    // alias just outside the region must not reach the register
    acc(1'b1, 32'h01b40000, 32'h0, r);
    acc(1'b0, PES, 32'h0, r);
    chk("region", 32'h60, r);
    acc(1'b1, LCK, 32'h0, r);
    acc(1'b1, PES, 32'h40, r);
    chk("vp1_clear", 32'h1, {31'h0, video_port2_enable & ~video_port1_enable});
    // unlock and enable in adjacent cycles, random data with port 2 forced on
    d = $random(seed);
    d[rsdc_pkg::RSDC_VP2_BIT] = 1'b1;
    acc_pair(LCK, rsdc_pkg::RSDC_UNLOCK_KEY, PES, d);
    acc(1'b0, PES, 32'h0, r);
    chk("pes_pair", d & 32'h60, r);
    acc(1'b0, 32'h01b40000, 32'h0, r);
    chk("region_read", 32'h0, r);
    $display("test registers done");
    // second reset mid-run: enables and lock return to defaults, straps resampled
    @(posedge clk);
    #1 rstn = 1'b0;
    e = exp_cfg(level);
    repeat (10) @(posedge clk);
    #1 rstn = 1'b1;
    chk("vp_after_reset", 32'h0, {30'h0, video_port2_enable, video_port1_enable});
    acc(1'b0, LCK, 32'h0, r);
    chk("lock_after_reset", 32'h1, r);
    chk("dev_cfg_rerun", {14'h0, e}, {14'h0, dev_cfg});
    $display("test mid-run reset done");
    print_verdict();
  end
endmodule : rsdc_top_tb
